// ===== pkg/rmp_pkg.sv
package rmp_pkg;

  // ----------------------------------------------------------------
  // Bus addressing
  // ----------------------------------------------------------------
  localparam logic [4:0] DEF_ADDR   = 5'h05;
  localparam logic [2:0] GRP_LISTEN = 3'h1;
  localparam logic [2:0] GRP_TALK   = 3'h2;
  localparam logic [7:0] BC_UNL     = 8'h3f;
  localparam logic [7:0] BC_UNT     = 8'h5f;
  localparam logic [7:0] BC_DCL     = 8'h14;
  localparam logic [7:0] BC_SDC     = 8'h04;

  // ----------------------------------------------------------------
  // Characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_SEMI  = 8'h3b;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_DQ    = 8'h22;
  localparam logic [7:0] CH_SQ    = 8'h27;
  localparam logic [7:0] CH_QM    = 8'h3f;
  localparam logic [7:0] CH_PLUS  = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_DOT   = 8'h2e;
  localparam logic [7:0] CH_EXP   = 8'h45;
  localparam logic [7:0] CH_U     = 8'h55;

  // ----------------------------------------------------------------
  // Error magnitudes (reported negative)
  // ----------------------------------------------------------------
  localparam logic [7:0] ERR_SYNTAX  = 8'h66;
  localparam logic [7:0] ERR_PCOUNT  = 8'h6d;
  localparam logic [7:0] ERR_UNKNOWN = 8'h71;
  localparam logic [7:0] ERR_LOCAL   = 8'hc9;
  localparam logic [7:0] ERR_RANGE   = 8'hde;

  // ----------------------------------------------------------------
  // Mnemonics and operations
  // ----------------------------------------------------------------
  localparam logic [23:0] MN_AVL = 24'h415441;
  localparam logic [23:0] MN_DEG = 24'h415444;
  localparam logic [23:0] MN_INT = 24'h415445;
  localparam logic [23:0] MN_SER = 24'h534552;
  localparam logic [23:0] MN_ID  = 24'h004944;
  localparam logic [23:0] MN_ERR = 24'h455252;
  localparam logic [23:0] MN_LBL = 24'h4c424c;
  localparam logic [2:0]  OP_AVL = 3'h0;
  localparam logic [2:0]  OP_DEG = 3'h1;
  localparam logic [2:0]  OP_INT = 3'h2;
  localparam logic [2:0]  OP_SER = 3'h3;
  localparam logic [2:0]  OP_ID  = 3'h4;
  localparam logic [2:0]  OP_ERR = 3'h5;
  localparam logic [2:0]  OP_LBL = 3'h6;
  localparam logic [2:0]  OP_BAD = 3'h7;
  localparam logic [15:0] THR_MAX = 16'h2710;

  typedef enum logic [4:0] {
    ST_CMD  = 5'b00001,
    ST_MNEM = 5'b00010,
    ST_PARM = 5'b00100,
    ST_STR  = 5'b01000,
    ST_SKIP = 5'b10000
  } rmp_state_t;

  typedef struct packed {
    logic       atn;
    logic [7:0] data;
  } rmp_rx_t;

  typedef struct packed {
    logic [2:0]  op;
    logic [15:0] value;
    logic        flag;
    logic [63:0] text;
  } rmp_cmd_t;

endpackage

// ===== rtl/rmp_parser.sv
// Notes on behaviour
// - Listen and talk address is 05 unless the address switch is enabled.
// - Messages split at each semicolon into separate commands.
// - Commands are mnemonics of up to three letters, then parameters.
// - LF alone, or CR then LF, ends a message.
// - Bad syntax, unknown name, wrong count, range or context is rejected.
// - After a rejection the rest of the message is discarded.
// - A mnemonic with question mark loads a reply read when talking.
// - String parameters may be in double or single quotes.
// - Character replies are the bare ID text, without quotes.
// - Serial reply is four digits, U, five digits, in double quotes.
// - Numeric replies are signed integer, decimal or exponent form.
// - Threshold replies give enable flag, comma, then threshold value.
// - Error query returns the error register as signed integer.
// - Data is taken while listening, whoever else listens too.
// - Device clear stops gating, flushes, clears errors, sets ready.
// - Interface clear unaddresses only; parser and buffers keep state.
// - Configuration command in local mode is refused with error -201.
module rmp_parser #(
  parameter logic [35:0] SER_BCD = 36'h123456789, // Arbitrary value
  parameter logic [63:0] ID_TEXT = 64'h5453545f554e4954 // Arbitrary value
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             RESET_N,
  // Bus receive side
  input  wire logic             RX_VALID,
  input  wire rmp_pkg::rmp_rx_t RX,
  // Pins
  input  wire logic             IFC_PIN,
  input  wire logic             REN_PIN,
  input  wire logic             ADDR_SEL_EN,
  input  wire logic [4:0]       ADDR_SEL,
  // Bus transmit side
  input  wire logic             TX_READY,
  output logic                  TX_VALID,
  output logic [7:0]            TX_DATA,
  output logic                  TX_LAST,
  // Status
  output logic                  LISTEN,
  output logic                  TALK,
  output logic                  REMOTE,
  output logic                  READY,
  output logic                  GATE_STOP,
  // Executed commands
  output logic                  CMD_VALID,
  output rmp_pkg::rmp_cmd_t     CMD
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] sy1_r, sy2_r, sy3_r, pin_r;
  logic       ifc, ren, aen;
  logic [4:0] asel, my_addr;

  always_ff @(posedge CLK)
  begin
    sy1_r <= {ADDR_SEL_EN, ADDR_SEL, IFC_PIN, REN_PIN};
    sy2_r <= sy1_r;
    sy3_r <= sy2_r;
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      pin_r <= 8'h00;
    else
      pin_r <= (~(sy2_r ^ sy3_r) & sy2_r) | ((sy2_r ^ sy3_r) & pin_r);
  end

  assign aen     = pin_r[7];
  assign asel    = pin_r[6:2];
  assign ifc     = pin_r[1];
  assign ren     = pin_r[0];
  assign my_addr = aen ? asel : rmp_pkg::DEF_ADDR;

  // ----------------------------------------------------------------
  // Bus addressing and clears
  // ----------------------------------------------------------------
  logic listen_r, talk_r, rem_r, gstop_r, bcmd, clr, lag;

  assign bcmd = RX_VALID && RX.atn;
  assign lag  = RX.data == {rmp_pkg::GRP_LISTEN, my_addr};
  assign clr  = bcmd && (RX.data == rmp_pkg::BC_DCL
              || (RX.data == rmp_pkg::BC_SDC && listen_r));

  always_ff @(posedge CLK)
  begin
    if (!RESET_N || ifc)
    begin
      listen_r <= 1'b0;
      talk_r   <= 1'b0;
    end
    else if (bcmd)
    begin
      if (RX.data == rmp_pkg::BC_UNL)
        listen_r <= 1'b0;
      else if (RX.data == rmp_pkg::BC_UNT)
        talk_r <= 1'b0;
      else if (lag)
        listen_r <= 1'b1;
      else if (RX.data[7:5] == rmp_pkg::GRP_TALK)
        talk_r <= RX.data[4:0] == my_addr;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N || !ren)
      rem_r <= 1'b0;
    else if (bcmd && lag)
      rem_r <= 1'b1;
  end

  always_ff @(posedge CLK)
  begin
    gstop_r <= RESET_N && clr;
  end

  // ----------------------------------------------------------------
  // Character classes
  // ----------------------------------------------------------------
  logic [7:0]  ch;
  logic        dat, is_let, is_dig, is_sp, is_term;
  logic [19:0] acc10;

  assign ch      = RX.data;
  assign dat     = RX_VALID && !RX.atn && listen_r && !ifc;
  assign is_let  = (ch >= 8'h41 && ch <= 8'h5a) || (ch >= 8'h61 && ch <= 8'h7a);
  assign is_dig  = ch >= 8'h30 && ch <= 8'h39;
  assign is_sp   = ch == rmp_pkg::CH_SP || ch == rmp_pkg::CH_CR;
  assign is_term = ch == rmp_pkg::CH_SEMI || ch == rmp_pkg::CH_LF;

  // ----------------------------------------------------------------
  // Parser state
  // ----------------------------------------------------------------
  rmp_pkg::rmp_state_t st_r;
  logic [23:0] mn_r;
  logic [1:0]  nl_r, nc_r;
  logic [15:0] val_r, p0_r;
  logic [63:0] txt_r;
  logic [7:0]  qc_r;
  logic        qry_r, hp_r, ovf_r, bad_r, str_r;
  logic [7:0]  err_c;

  assign acc10 = {1'b0, val_r, 3'h0} + {3'h0, val_r, 1'b0} + {16'h0, ch[3:0]};

  always_ff @(posedge CLK)
  begin
    if (!RESET_N || clr)
    begin
      st_r  <= rmp_pkg::ST_CMD;
      mn_r  <= 24'h000000;
      nl_r  <= 2'h0;
      nc_r  <= 2'h0;
      val_r <= 16'h0000;
      p0_r  <= 16'h0000;
      txt_r <= 64'h0;
      qc_r  <= 8'h00;
      qry_r <= 1'b0;
      hp_r  <= 1'b0;
      ovf_r <= 1'b0;
      bad_r <= 1'b0;
      str_r <= 1'b0;
    end
    else if (dat)
    begin
      unique case (st_r)
        rmp_pkg::ST_CMD:
          if (is_let)
          begin
            mn_r  <= {16'h0000, ch};
            nl_r  <= 2'h1;
            nc_r  <= 2'h0;
            val_r <= 16'h0000;
            p0_r  <= 16'h0000;
            txt_r <= 64'h0;
            qry_r <= 1'b0;
            hp_r  <= 1'b0;
            ovf_r <= 1'b0;
            bad_r <= 1'b0;
            str_r <= 1'b0;
            st_r  <= rmp_pkg::ST_MNEM;
          end
          else if (!(is_sp || is_term))
            st_r <= rmp_pkg::ST_SKIP;
        rmp_pkg::ST_MNEM, rmp_pkg::ST_PARM:
          if (is_term)
            st_r <= (err_c != 8'h00 && ch != rmp_pkg::CH_LF)
                  ? rmp_pkg::ST_SKIP : rmp_pkg::ST_CMD;
          else if (st_r == rmp_pkg::ST_MNEM && is_let)
          begin
            mn_r <= {mn_r[15:0], ch};
            nl_r <= nl_r + 2'h1;
            if (nl_r == 2'h3 || qry_r)
              bad_r <= 1'b1;
          end
          else if (st_r == rmp_pkg::ST_MNEM && ch == rmp_pkg::CH_QM)
          begin
            qry_r <= 1'b1;
            bad_r <= bad_r | qry_r;
          end
          else
          begin
            st_r <= rmp_pkg::ST_PARM;
            if (is_dig)
            begin
              val_r <= acc10[15:0];
              ovf_r <= ovf_r | (acc10[19:16] != 4'h0);
              hp_r  <= 1'b1;
            end
            else if (ch == rmp_pkg::CH_COMMA)
            begin
              p0_r  <= val_r;
              val_r <= 16'h0000;
              nc_r  <= (nc_r == 2'h3) ? nc_r : nc_r + 2'h1;
              hp_r  <= 1'b1;
            end
            else if (ch == rmp_pkg::CH_DQ || ch == rmp_pkg::CH_SQ)
            begin
              qc_r  <= ch;
              str_r <= 1'b1;
              hp_r  <= 1'b1;
              st_r  <= rmp_pkg::ST_STR;
            end
            else if (!is_sp)
              bad_r <= 1'b1;
          end
        rmp_pkg::ST_STR:
          if (ch == qc_r)
            st_r <= rmp_pkg::ST_PARM;
          else if (ch == rmp_pkg::CH_LF)
            st_r <= rmp_pkg::ST_CMD;
          else
            txt_r <= {txt_r[55:0], ch};
        rmp_pkg::ST_SKIP:
          if (ch == rmp_pkg::CH_LF)
            st_r <= rmp_pkg::ST_CMD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command check
  // ----------------------------------------------------------------
  logic [2:0] op;
  logic [7:0] rej_code;
  logic       fin, lead_bad, rej, acc;

  always_comb
  begin
    unique case (mn_r)
      rmp_pkg::MN_AVL: op = rmp_pkg::OP_AVL;
      rmp_pkg::MN_DEG: op = rmp_pkg::OP_DEG;
      rmp_pkg::MN_INT: op = rmp_pkg::OP_INT;
      rmp_pkg::MN_SER: op = rmp_pkg::OP_SER;
      rmp_pkg::MN_ID:  op = rmp_pkg::OP_ID;
      rmp_pkg::MN_ERR: op = rmp_pkg::OP_ERR;
      rmp_pkg::MN_LBL: op = rmp_pkg::OP_LBL;
      default:         op = rmp_pkg::OP_BAD;
    endcase
  end

  always_comb
  begin
    err_c = 8'h00;
    if (bad_r)
      err_c = rmp_pkg::ERR_SYNTAX;
    else if (op == rmp_pkg::OP_BAD || (qry_r && op == rmp_pkg::OP_LBL)
             || (!qry_r && op >= rmp_pkg::OP_SER && op <= rmp_pkg::OP_ERR))
      err_c = rmp_pkg::ERR_UNKNOWN;
    else if (qry_r)
      err_c = hp_r ? rmp_pkg::ERR_PCOUNT : 8'h00;
    else if (op == rmp_pkg::OP_LBL)
      err_c = (!str_r || nc_r != 2'h0) ? rmp_pkg::ERR_PCOUNT
            : (rem_r ? 8'h00 : rmp_pkg::ERR_LOCAL);
    else if (!hp_r || nc_r != 2'h1 || str_r)
      err_c = rmp_pkg::ERR_PCOUNT;
    else if (ovf_r || p0_r > 16'h0001 || val_r > rmp_pkg::THR_MAX)
      err_c = rmp_pkg::ERR_RANGE;
    else if (!rem_r)
      err_c = rmp_pkg::ERR_LOCAL;
  end

  assign fin = dat && is_term
            && (st_r == rmp_pkg::ST_MNEM || st_r == rmp_pkg::ST_PARM);
  assign lead_bad = dat && ch != rmp_pkg::CH_SEMI && ((st_r == rmp_pkg::ST_CMD
            && !(is_let || is_sp || is_term))
            || (st_r == rmp_pkg::ST_STR && ch == rmp_pkg::CH_LF));
  assign rej      = (fin && err_c != 8'h00) || lead_bad;
  assign rej_code = lead_bad ? rmp_pkg::ERR_SYNTAX : err_c;
  assign acc      = fin && err_c == 8'h00;

  // ----------------------------------------------------------------
  // Error register and ready
  // ----------------------------------------------------------------
  logic [7:0] err_r;
  logic       ready_r;

  always_ff @(posedge CLK)
  begin
    if (!RESET_N || clr)
      err_r <= 8'h00;
    else if (rej)
      err_r <= rej_code;
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N || clr)
      ready_r <= 1'b1;
    else if (dat)
      ready_r <= ch == rmp_pkg::CH_LF;
  end

  // ----------------------------------------------------------------
  // Execution
  // ----------------------------------------------------------------
  logic [15:0]       thr_v_r [0:2];
  logic [2:0]        thr_f_r, qs_r;
  logic              cmd_v_r, qx_r;
  rmp_pkg::rmp_cmd_t cmd_r;

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      thr_f_r    <= 3'h0;
      thr_v_r[0] <= 16'h0000;
      thr_v_r[1] <= 16'h0000;
      thr_v_r[2] <= 16'h0000;
    end
    else if (acc && !qry_r && op <= rmp_pkg::OP_INT)
    begin
      thr_f_r[op[1:0]] <= p0_r[0];
      thr_v_r[op[1:0]] <= val_r;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N || clr)
    begin
      cmd_v_r <= 1'b0;
      cmd_r   <= '0;
      qx_r    <= 1'b0;
      qs_r    <= 3'h0;
    end
    else
    begin
      cmd_v_r <= acc && !qry_r;
      qx_r    <= acc && qry_r;
      if (acc)
      begin
        cmd_r <= '{op: op, value: val_r, flag: p0_r[0], text: txt_r};
        qs_r  <= op;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reply formatting and output
  // ----------------------------------------------------------------
  function automatic logic [19:0] to_bcd(input logic [15:0] b);
    logic [35:0] s;
    s = {20'h0, b};
    for (int i = 0; i < 16; i++)
    begin
      for (int j = 0; j < 5; j++)
        if (s[16 + 4 * j +: 4] > 4'h4)
          s[16 + 4 * j +: 4] = s[16 + 4 * j +: 4] + 4'h3;
      s = {s[34:0], 1'b0};
    end
    return s[35:16];
  endfunction

  function automatic logic [7:0] asc(input logic [3:0] d);
    return {4'h3, d};
  endfunction

  logic [127:0] rsh_r;
  logic [4:0]   rlen_r;
  logic [19:0]  d;
  logic [7:0]   fc, sg;
  logic         fire;

  assign d    = to_bcd(qs_r <= rmp_pkg::OP_INT ? thr_v_r[qs_r[1:0]]
                                              : {8'h00, err_r});
  assign fc   = {7'h18, thr_f_r[qs_r[1:0]]};
  assign sg   = err_r == 8'h00 ? rmp_pkg::CH_PLUS : rmp_pkg::CH_MINUS;
  assign fire = TX_VALID && TX_READY;

  always_ff @(posedge CLK)
  begin
    if (!RESET_N || clr)
    begin
      rsh_r  <= 128'h0;
      rlen_r <= 5'h00;
    end
    else if (qx_r)
    begin
      unique case (qs_r)
        rmp_pkg::OP_AVL, rmp_pkg::OP_DEG:
        begin
          rsh_r  <= {fc, rmp_pkg::CH_COMMA, asc(d[19:16]), asc(d[15:12]),
                     asc(d[11:8]), rmp_pkg::CH_DOT, asc(d[7:4]),
                     asc(d[3:0]), rmp_pkg::CH_LF, 56'h0};
          rlen_r <= 5'h09;
        end
        rmp_pkg::OP_INT:
        begin
          rsh_r  <= {fc, rmp_pkg::CH_COMMA, asc(d[19:16]), rmp_pkg::CH_DOT,
                     asc(d[15:12]), asc(d[11:8]), asc(d[7:4]), asc(d[3:0]),
                     rmp_pkg::CH_EXP, asc(4'h4), rmp_pkg::CH_LF, 40'h0};
          rlen_r <= 5'h0b;
        end
        rmp_pkg::OP_SER:
        begin
          rsh_r  <= {rmp_pkg::CH_DQ, asc(SER_BCD[35:32]),
                     asc(SER_BCD[31:28]), asc(SER_BCD[27:24]),
                     asc(SER_BCD[23:20]), rmp_pkg::CH_U,
                     asc(SER_BCD[19:16]), asc(SER_BCD[15:12]),
                     asc(SER_BCD[11:8]), asc(SER_BCD[7:4]),
                     asc(SER_BCD[3:0]), rmp_pkg::CH_DQ, rmp_pkg::CH_LF,
                     24'h0};
          rlen_r <= 5'h0d;
        end
        rmp_pkg::OP_ID:
        begin
          rsh_r  <= {ID_TEXT, rmp_pkg::CH_LF, 56'h0};
          rlen_r <= 5'h09;
        end
        default:
        begin
          rsh_r  <= {sg, asc(d[11:8]), asc(d[7:4]), asc(d[3:0]),
                     rmp_pkg::CH_LF, 88'h0};
          rlen_r <= 5'h05;
        end
      endcase
    end
    else if (fire)
    begin
      rsh_r  <= {rsh_r[119:0], 8'h00};
      rlen_r <= rlen_r - 5'h01;
    end
  end

  // Interface clear must not drain the pending reply
  assign TX_VALID  = talk_r && !ifc && rlen_r != 5'h00;
  assign TX_DATA   = rsh_r[127:120];
  assign TX_LAST   = rlen_r == 5'h01;
  assign LISTEN    = listen_r;
  assign TALK      = talk_r;
  assign REMOTE    = rem_r;
  assign READY     = ready_r;
  assign GATE_STOP = gstop_r;
  assign CMD_VALID = cmd_v_r;
  assign CMD       = cmd_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ADDR: assert property (@(posedge CLK) disable iff (!RESET_N)
    bcmd && !ifc && !aen && RX.data == 8'h25 |=> LISTEN)
    else $error("default listen address not taken");
  AST_SPLIT: assert property (@(posedge CLK) disable iff (!RESET_N)
    fin && acc && !qry_r && ch == rmp_pkg::CH_SEMI
    |=> CMD_VALID && st_r == rmp_pkg::ST_CMD)
    else $error("semicolon did not execute command");
  AST_TERM: assert property (@(posedge CLK) disable iff (!RESET_N)
    dat && ch == rmp_pkg::CH_LF && !clr |=> READY && st_r == rmp_pkg::ST_CMD)
    else $error("linefeed did not end message");
  AST_REJ: assert property (@(posedge CLK) disable iff (!RESET_N)
    rej && !clr |=> err_r != 8'h00 && err_r == $past(rej_code) && !CMD_VALID)
    else $error("rejection not recorded");
  AST_SKIP: assert property (@(posedge CLK) disable iff (!RESET_N)
    st_r == rmp_pkg::ST_SKIP && !(dat && ch == rmp_pkg::CH_LF)
    |=> !CMD_VALID ##1 !CMD_VALID)
    else $error("command executed after rejection");
  AST_LOCAL: assert property (@(posedge CLK) disable iff (!RESET_N)
    fin && !bad_r && !qry_r && !rem_r && op <= rmp_pkg::OP_INT && hp_r
    && nc_r == 2'h1 && !str_r && !ovf_r && p0_r <= 16'h0001
    && val_r <= rmp_pkg::THR_MAX |=> err_r == rmp_pkg::ERR_LOCAL)
    else $error("local mode change not refused");
  AST_CLR: assert property (@(posedge CLK) disable iff (!RESET_N)
    clr |=> READY && err_r == 8'h00 && GATE_STOP && !TX_VALID
    && st_r == rmp_pkg::ST_CMD)
    else $error("device clear incomplete");
  AST_IFC: assert property (@(posedge CLK) disable iff (!RESET_N)
    ifc && !clr |=> !LISTEN && !TALK && st_r == $past(st_r)
    && rlen_r == $past(rlen_r))
    else $error("interface clear disturbed parser");
  AST_QRY: assert property (@(posedge CLK) disable iff (!RESET_N)
    acc && qry_r && !clr |=> qx_r ##1 rlen_r != 5'h00)
    else $error("query reply not prepared");

endmodule

// ===== dv/rmp_ctrl.sv
module rmp_ctrl (
  // Clock
  input  wire logic        CLK,
  // Reply side
  input  wire logic        TX_VALID,
  input  wire logic [7:0]  TX_DATA,
  output logic             TX_READY,
  // Bus bytes
  output logic             RX_VALID,
  output rmp_pkg::rmp_rx_t RX
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pace_r = 2'h0;

  initial
  begin
    RX_VALID = 1'b0;
    RX = 9'h000;
  end

  // Reader stalls one cycle in four
  always @(posedge CLK) pace_r <= pace_r + 2'h1;
  assign TX_READY = (pace_r != 2'h3);

  // One byte per pulse; released lines show the inverse of the last value
  task automatic send(input logic atn, input logic [7:0] b);
    @(posedge CLK);
    RX_VALID <= 1'b1;
    RX <= {atn, b};
    @(posedge CLK);
    RX_VALID <= 1'b0;
    RX <= {~atn, ~b};
  endtask
endmodule

// ===== dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, RESET_N = 0, IFC_PIN = 0, REN_PIN = 1;
  logic ADDR_SEL_EN = 0;
  logic [4:0] ADDR_SEL = 5'h00;
  logic RX_VALID, TX_READY, TX_VALID, TX_LAST, LISTEN, TALK, REMOTE;
  logic READY, GATE_STOP, CMD_VALID;
  logic [7:0] TX_DATA, te;
  rmp_pkg::rmp_rx_t RX;
  rmp_pkg::rmp_cmd_t CMD;
  logic [20:0] cq[$], ce;
  logic [7:0] tq[$];
  int err_total = 0, n_checks = 0, seed = 61, t, f, v;
  string s, bad[4], code[4];

  initial forever #25 CLK = ~CLK;

  rmp_parser dut (.CLK, .RESET_N, .RX_VALID, .RX, .IFC_PIN, .REN_PIN,
    .ADDR_SEL_EN, .ADDR_SEL, .TX_READY, .TX_VALID,
    .TX_DATA, .TX_LAST, .LISTEN, .TALK, .REMOTE, .READY, .GATE_STOP,
    .CMD_VALID, .CMD);
  rmp_ctrl ctrl (.CLK, .TX_VALID, .TX_DATA, .TX_READY, .RX_VALID, .RX);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic msg(string m);
    for (int i = 0; i < m.len(); i++)
      ctrl.send(1'b0, m[i]);
  endtask

  task automatic drain;
    repeat (4) @(posedge CLK);
    t = 0;
    while ((cq.size() + tq.size()) > 0 && t < 400)
    begin
      @(posedge CLK);
      t++;
    end
    chk(t < 400, 1);
  endtask

  // Query while listening, then read the reply as talker
  task automatic q(string m, string r);
    msg(m);
    for (int i = 0; i < r.len(); i++)
      tq.push_back(r[i]);
    ctrl.send(1'b1, 8'h45);
    drain;
    ctrl.send(1'b1, 8'h5f);
  endtask

  // ----------------------------------------------------------------
  // Output monitor
  // ----------------------------------------------------------------
  always @(posedge CLK)
  begin
    if (CMD_VALID === 1'b1)
    begin
      ce = (cq.size() > 0) ? cq.pop_front() : 21'h1fffff;
      if (ce[20])
        chk({CMD.op, CMD.text[23:0]}, {ce[19:17], 8'h00, ce[16:1]});
      else
        chk({CMD.op, CMD.flag, CMD.value}, ce[19:0]);
    end
    if (TX_VALID === 1'b1 && TX_READY === 1'b1)
    begin
      te = (tq.size() > 0) ? tq.pop_front() : 8'hff;
      chk({TX_LAST, TX_DATA}, {te == 8'h0a, te});
    end
  end

  initial
  begin
    repeat (20000) @(posedge CLK);
    err_total++;
    results;
  end

  initial
  begin
    bad = '{"XYZ1;ATA1,7\n", "ATA1,10001\n", "ATA1\n", "#ATA1,5\n"};
    code = '{"-113\n", "-222\n", "-109\n", "-102\n"};
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (4) @(posedge CLK);
    chk({READY, LISTEN, TALK}, 3'h4);
    ctrl.send(1'b1, 8'h25);
    #1 chk({LISTEN, REMOTE}, 2'h3);
    cq.push_back({1'b0, 3'h0, 1'b1, 16'h0005});
    cq.push_back({1'b0, 3'h1, 1'b0, 16'h0014});
    cq.push_back({1'b0, 3'h2, 1'b1, 16'h001e});
    msg("ATA1,5\n");
    msg("ATD0,20;ATE1,30\r\n");
    drain;
    $display("test settings done");
    for (int i = 0; i < 4; i++)
    begin
      msg(bad[i]);
      q("ERR?\n", code[i]);
    end
    $display("test rejects done");
    q("ATA?\n", "1,000.05\n");
    q("ATD?\n", "0,000.20\n");
    q("SER?\n", "\"1234U56789\"\n");
    q("ID?\n", "TST_UNIT\n");
    $display("test queries done");
    cq.push_back({1'b1, 3'h6, 16'h4142, 1'b0});
    cq.push_back({1'b1, 3'h6, 16'h4344, 1'b0});
    msg("LBL\"AB\"\n");
    msg("LBL'CD'\n");
    s = "";
    for (int i = 0; i < 5; i++)
    begin
      f = $random(seed) & 1;
      v = {$random(seed)} % 10001;
      cq.push_back({1'b0, 3'h1, f[0], v[15:0]});
      if (i > 0)
        s = {s, ";"};
      s = {s, $sformatf("ATD%0d,%0d", f, v)};
    end
    msg({s, "\n"});
    drain;
    $display("test strings and order done");
    REN_PIN <= 1'b0;
    repeat (6) @(posedge CLK);
    chk(REMOTE, 0);
    msg("ATA0,1\n");
    q("ERR?\n", "-201\n");
    REN_PIN <= 1'b1;
    repeat (5) @(posedge CLK);
    ctrl.send(1'b1, 8'h25);
    $display("test local done");
    msg("ATA1,");
    chk(READY, 0);
    ctrl.send(1'b1, 8'h14);
    #1 chk({GATE_STOP, READY}, 2'h3);
    q("ERR?\n", "+000\n");
    chk(READY, 1);
    $display("test clear done");
    IFC_PIN <= 1'b1;
    repeat (6) @(posedge CLK);
    chk({LISTEN, TALK}, 2'h0);
    IFC_PIN <= 1'b0;
    repeat (5) @(posedge CLK);
    msg("ATA0,9\n");
    ctrl.send(1'b1, 8'h25);
    q("ATA?\n", "1,000.05\n");
    $display("test interface clear done");
    ADDR_SEL <= 5'h07;
    ADDR_SEL_EN <= 1'b1;
    ctrl.send(1'b1, 8'h3f);
    repeat (6) @(posedge CLK);
    ctrl.send(1'b1, 8'h25);
    #1 chk(LISTEN, 0);
    ctrl.send(1'b1, 8'h27);
    #1 chk(LISTEN, 1);
    $display("test address select done");
    results;
  end
endmodule
